//--- hdl/clock_gate_pkg.sv
// Shared types and constants for the differential clock output gating block
package clock_gate_pkg;

   localparam int PAIR_COUNT = 4;
   localparam int SYNC_STAGES = 2;
   localparam int DEBOUNCE_SAMPLES = 2;

   // Timing: 125 MHz system clock
   localparam int CLOCK_PERIOD_PS = 8000;
   localparam int RELEASE_DRIVE_NS = 10;
   localparam int RELEASE_DRIVE_RAW =
      (RELEASE_DRIVE_NS * 1000) / CLOCK_PERIOD_PS;
   localparam int RELEASE_DRIVE_CYCLES =
      (RELEASE_DRIVE_RAW < 1) ? 1 : RELEASE_DRIVE_RAW;
   localparam int RESUME_MAX_PERIODS = 6;
   // Slowest internal output period: half rate from the internal source
   localparam int SLOW_PERIOD_CYCLES = 4;
   localparam int RESUME_MAX_CYCLES = RESUME_MAX_PERIODS * SLOW_PERIOD_CYCLES;
   localparam int RATE_SWITCH_CYCLES = SLOW_PERIOD_CYCLES;

   typedef enum logic [1:0] {
      PAIR_RUN  = 2'h0,
      PAIR_PARK = 2'h1,
      PAIR_HIGH = 2'h3,
      PAIR_OFF  = 2'h2
   } pair_state_type;

   typedef struct packed {
      logic true_out;
      logic true_oe;
      logic true_strong;
      logic comp_out;
      logic comp_oe;
   } pair_drive_type;

   typedef struct packed {
      logic output_stop_n;
      logic ref_clock_in_true;
      logic pll_select;
      logic bandwidth_select_n;
      logic [PAIR_COUNT-1:0] output_enable_pin;
   } pin_in_type;

   typedef struct packed {
      logic half_rate_bit;
      logic stop_tristate_bit;
      logic pll_mode_bit;
      logic bandwidth_bit;
      logic [PAIR_COUNT-1:0] output_enable_bits;
      logic [PAIR_COUNT-1:0] stop_allow_bits;
   } config_type;

   localparam int PIN_WIDTH = $bits(pin_in_type);
   localparam pin_in_type PIN_RESET = '{
      output_stop_n: 1'b1,
      ref_clock_in_true: 1'b0,
      pll_select: 1'b1,
      bandwidth_select_n: 1'b1,
      output_enable_pin: 4'h0
   };
   localparam pair_drive_type DRIVE_OFF = '0;
   localparam logic STOP_IDLE_LEVEL = 1'b1;

endpackage : clock_gate_pkg

//--- hdl/pin_sync.sv
// Two-stage synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_q
);

   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta_q <= RESET_VALUE;
         sync_q <= RESET_VALUE;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

endmodule : pin_sync

//--- hdl/diff_clock_output_gating.sv
// Output gating, stop, enable, rate and path control for four clock pairs
`timescale 1ns/1ps

module diff_clock_output_gating (
   input wire logic clock,
   input wire logic rst_n,
   input wire clock_gate_pkg::pin_in_type pins,
   input wire clock_gate_pkg::config_type config_bits,
   output clock_gate_pkg::pair_drive_type [clock_gate_pkg::PAIR_COUNT-1:0]
      pair_drive,
   output logic stop_active,
   output logic pll_mode,
   output logic low_bandwidth,
   output logic half_rate_active
);
   import clock_gate_pkg::*;

   localparam int RELEASE_CYC = RELEASE_DRIVE_CYCLES;
   localparam int RESUME_CYC = RESUME_MAX_CYCLES;
   localparam int RATE_CYC = RATE_SWITCH_CYCLES;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   pin_in_type pin_s;
   logic master_q;
   logic master_d;
   logic div_q;
   logic ref_prev_q;
   logic path_pll_q;
   logic half_active_q;
   logic pll_mode_q;
   logic low_bw_q;
   logic stop_sample_q;
   logic stop_level_q;

   // Every pin is synchronised before any logic looks at it
   pin_sync #(
      .WIDTH(PIN_WIDTH),
      .RESET_VALUE(PIN_RESET)
   ) u_pin_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in(pins),
      .sync_q(pin_s)
   );

   // Mode targets from register bits and pins; half rate from its register bit only
   wire logic pll_target;
   wire logic low_bw_target;
   wire logic half_target;
   assign pll_target = config_bits.pll_mode_bit & pin_s.pll_select;
   assign low_bw_target =
      ~config_bits.bandwidth_bit | ~pin_s.bandwidth_select_n;
   assign half_target = ~config_bits.half_rate_bit;

   // Output clock source: internal toggle or the input clock itself
   wire logic ref_rise;
   wire logic pll_next;
   wire logic byp_next;
   wire logic rise_ev;
   wire logic fall_ev;
   wire logic switch_ok;
   assign ref_rise = pin_s.ref_clock_in_true & ~ref_prev_q;
   assign pll_next = half_active_q ? (master_q ^ div_q) : ~master_q;
   assign byp_next = half_active_q ? (master_q ^ ref_rise)
                                   : pin_s.ref_clock_in_true;
   assign master_d = path_pll_q ? pll_next : byp_next;
   assign rise_ev = master_d & ~master_q;
   assign fall_ev = ~master_d & master_q;
   // Path and rate only change while the output sits low
   assign switch_ok = ~master_d;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         master_q <= 1'b0;
         div_q <= 1'b0;
         ref_prev_q <= 1'b0;
      end else begin
         master_q <= master_d;
         div_q <= ~div_q;
         ref_prev_q <= pin_s.ref_clock_in_true;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pll_mode_q <= 1'b1;
         low_bw_q <= 1'b0;
         path_pll_q <= 1'b1;
         half_active_q <= 1'b0;
      end else begin
         pll_mode_q <= pll_target;
         low_bw_q <= low_bw_target;
         if (switch_ok) begin
            path_pll_q <= pll_mode_q;
            half_active_q <= half_target;
         end
      end
   end

   // Stop debounce, sampled where the complementary output rises;
   // with no input clock in bypass no sample is taken
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stop_sample_q <= STOP_IDLE_LEVEL;
         stop_level_q <= STOP_IDLE_LEVEL;
      end else if (fall_ev) begin
         stop_sample_q <= pin_s.output_stop_n;
         if (stop_sample_q == pin_s.output_stop_n) begin
            stop_level_q <= pin_s.output_stop_n;
         end
      end
   end

   assign stop_active = ~stop_level_q;
   assign pll_mode = pll_mode_q;
   assign low_bandwidth = low_bw_q;
   assign half_rate_active = half_active_q;

   generate
      for (genvar i = 0; i < PAIR_COUNT; i++) begin : g_pair
         pair_state_type state_q;
         pair_state_type state_d;
         pair_drive_type drive_q;
         pair_drive_type drive_d;
         wire logic pair_en;
         wire logic stop_req;
         wire logic park_ev;

         assign pair_en = config_bits.output_enable_bits[i]
                        & pin_s.output_enable_pin[i];
         assign stop_req = ~stop_level_q
                         & config_bits.stop_allow_bits[i];
         // Driven stop parks high, three-state stop parks low
         assign park_ev = config_bits.stop_tristate_bit ? fall_ev
                                                        : rise_ev;

         always_comb begin
            state_d = state_q;
            case (state_q)
               PAIR_RUN: begin
                  if (!pair_en && fall_ev) begin
                     state_d = PAIR_OFF;
                  end else if (stop_req && park_ev) begin
                     state_d = PAIR_PARK;
                  end
               end
               PAIR_PARK: begin
                  if (!pair_en) begin
                     state_d = PAIR_OFF;
                  end else if (!stop_req) begin
                     state_d = PAIR_HIGH;
                  end
               end
               PAIR_HIGH: begin
                  if (!pair_en) begin
                     state_d = PAIR_OFF;
                  end else if (stop_req) begin
                     state_d = PAIR_PARK;
                  end else if (rise_ev) begin
                     state_d = PAIR_RUN;
                  end
               end
               PAIR_OFF: begin
                  if (pair_en) begin
                     state_d = PAIR_HIGH;
                  end
               end
               default: begin
                  state_d = PAIR_OFF;
               end
            endcase
         end

         always_comb begin
            drive_d = DRIVE_OFF;
            case (state_d)
               PAIR_RUN: begin
                  drive_d.true_out = master_d;
                  drive_d.true_oe = 1'b1;
                  drive_d.comp_out = ~master_d;
                  drive_d.comp_oe = 1'b1;
               end
               PAIR_PARK: begin
                  if (!config_bits.stop_tristate_bit) begin
                     drive_d.true_out = 1'b1;
                     drive_d.true_oe = 1'b1;
                     drive_d.true_strong = 1'b1;
                  end
               end
               PAIR_HIGH: begin
                  drive_d.true_out = 1'b1;
                  drive_d.true_oe = 1'b1;
                  drive_d.comp_oe = 1'b1;
               end
               default: begin
                  drive_d = DRIVE_OFF;
               end
            endcase
         end

         always_ff @(posedge clock) begin
            if (!rst_n) begin
               state_q <= PAIR_OFF;
               drive_q <= DRIVE_OFF;
            end else begin
               state_q <= state_d;
               drive_q <= drive_d;
            end
         end

         assign pair_drive[i] = drive_q;

         sequence waiting_high;
            state_q == PAIR_HIGH && pair_en && !stop_req && path_pll_q;
         endsequence

         sequence stop_released;
            $fell(stop_req) && state_q == PAIR_PARK && pair_en;
         endsequence

         sequence entered_park;
            state_q == PAIR_PARK && $past(state_q) == PAIR_RUN;
         endsequence

         a_disable_tristate: assert property (
            (!pair_en && path_pll_q) [*8]
               |-> !drive_q.true_oe && !drive_q.comp_oe)
            else $error("disabled pair still driven");

         a_enable_high: assert property (
            $rose(pair_en) && !stop_req && state_q == PAIR_OFF
               |=> drive_q.true_out && drive_q.true_oe)
            else $error("enabled pair did not drive true high");

         a_release_high: assert property (
            stop_released
               |-> ##[1:RELEASE_CYC] (drive_q.true_out && drive_q.true_oe))
            else $error("released pair not driven high in time");

         a_resume_run: assert property (
            waiting_high |-> ##[1:RESUME_CYC] state_q != PAIR_HIGH)
            else $error("stopped pair did not resume in time");

         a_park_driven: assert property (
            state_q == PAIR_PARK && !$past(config_bits.stop_tristate_bit)
               |-> drive_q.true_out && drive_q.true_strong
                   && !drive_q.comp_oe && !drive_q.comp_out)
            else $error("driven stop level wrong");

         a_park_float: assert property (
            state_q == PAIR_PARK && $past(config_bits.stop_tristate_bit)
               |-> !drive_q.true_oe && !drive_q.comp_oe
                   && !drive_q.true_out)
            else $error("three-state stop level wrong");

         a_stop_edge: assert property (
            entered_park |-> $past(park_ev) && $past(stop_req))
            else $error("pair stopped off its edge or unasked");

         a_free_run: assert property (
            !config_bits.stop_allow_bits[i]
               && !$past(config_bits.stop_allow_bits[i])
               |-> state_q != PAIR_PARK)
            else $error("free-running pair was stopped");
      end
   endgenerate

   a_stop_debounce: assert property (
      stop_level_q != $past(stop_level_q)
         |-> $past(fall_ev)
             && $past(stop_sample_q) == $past(pin_s.output_stop_n))
      else $error("stop level changed without two equal samples");

   a_path_clean: assert property (
      path_pll_q != $past(path_pll_q) || half_active_q != $past(half_active_q)
         |-> !master_q)
      else $error("path or rate switched while output high");

   a_rate_switch: assert property (
      path_pll_q && half_active_q != half_target
         |-> ##[0:RATE_CYC] (half_active_q == half_target
                             || $changed(half_target) || !path_pll_q))
      else $error("rate switch took too long");

   a_bypass_route: assert property (
      !path_pll_q && !half_active_q && !$past(path_pll_q)
         && !$past(half_active_q)
         |-> master_q == $past(pin_s.ref_clock_in_true))
      else $error("bypass output does not follow input clock");

   a_bypass_select: assert property (
      ##1 pll_mode_q == ($past(config_bits.pll_mode_bit)
                         && $past(pin_s.pll_select)))
      else $error("bypass selection wrong");

   a_low_bandwidth: assert property (
      ##1 low_bw_q == (!$past(config_bits.bandwidth_bit)
                       || !$past(pin_s.bandwidth_select_n)))
      else $error("bandwidth selection wrong");

endmodule : diff_clock_output_gating

//--- sim/ref_source.sv
// Reference clock source standing in for the upstream clock synthesizer
`timescale 1ns/1ps
module ref_source #(
   parameter int HALF_NS = 25
) (
   input wire logic run,
   output logic ref_out
);
   // Unrelated in phase to the system clock; stands still when run is low
   initial begin
      ref_out = 1'b0;
      forever begin
         #(HALF_NS);
         if (run) ref_out = ~ref_out;
      end
   end
endmodule : ref_source

//--- sim/tb_top.sv
// Self-checking testbench for the clock output gating block
`timescale 1ns/1ps
module tb_top;
   import clock_gate_pkg::*;
   logic clock;
   logic rst_n;
   logic stop_n;
   logic pll_pin;
   logic bw_pin_n;
   logic [PAIR_COUNT-1:0] en_pin;
   logic ref_run;
   wire ref_clk;
   pin_in_type pins;
   config_type cfg;
   pair_drive_type [PAIR_COUNT-1:0] drive;
   logic stop_active;
   logic pll_mode;
   logic low_bandwidth;
   logic half_rate_active;
   logic [7:0] c;
   int failures;
   int comparisons;

   assign pins = {stop_n, ref_clk, pll_pin, bw_pin_n, en_pin};

   ref_source #(.HALF_NS(25)) partner (.run(ref_run), .ref_out(ref_clk));

   diff_clock_output_gating dut (
      .clock(clock),
      .rst_n(rst_n),
      .pins(pins),
      .config_bits(cfg),
      .pair_drive(drive),
      .stop_active(stop_active),
      .pll_mode(pll_mode),
      .low_bandwidth(low_bandwidth),
      .half_rate_active(half_rate_active)
   );

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clock);
         #1;
      end
   endtask : tick

   task automatic finish_test();
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test

   task automatic check(input string what, input logic [7:0] exp,
         input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      end
   endtask : check

   // Counts true output transitions of one pair over n cycles
   task automatic toggles(input int p, input int n, output logic [7:0] cnt);
      logic prev;
      cnt = 8'h0;
      prev = drive[p].true_out;
      repeat (n) begin
         tick(1);
         if (drive[p].true_out !== prev) cnt = cnt + 8'h1;
         prev = drive[p].true_out;
      end
   endtask : toggles

   task automatic wait_stop(input logic level);
      int k;
      k = 0;
      while (stop_active !== level && k < 40) begin
         tick(1);
         k++;
      end
      if (stop_active !== level) begin
         failures++;
         $display("unexpected stop_active: expected %0h, seen %0h", level,
            stop_active);
         finish_test();
      end
   endtask : wait_stop

   task automatic test_reset();
      check("drive after reset", 8'h1, {7'h0, drive === '0});
      check("stop_active after reset", 8'h0, {7'h0, stop_active});
      check("pll_mode after reset", 8'h1, {7'h0, pll_mode});
      check("half_rate after reset", 8'h0, {7'h0, half_rate_active});
   endtask : test_reset

   task automatic test_modes();
      logic [1:0] i;
      for (int n = 0; n < 4; n++) begin
         i = n[1:0];
         cfg.pll_mode_bit = i[0];
         cfg.bandwidth_bit = i[0];
         pll_pin = i[1];
         bw_pin_n = i[1];
         tick(4);
         check("pll_mode", {7'h0, i[0] & i[1]}, {7'h0, pll_mode});
         c = {7'h0, ~(i[0] & i[1])};
         check("low_bw", c, {7'h0, low_bandwidth});
      end
   endtask : test_modes

   task automatic test_enable();
      logic [1:0] i;
      for (int n = 0; n < 4; n++) begin
         i = n[1:0];
         cfg.output_enable_bits = {4{i[0]}};
         en_pin = {4{i[1]}};
         tick(30);
         toggles(1, 8, c);
         check("enabled oe", {7'h0, &i}, {7'h0, drive[1].true_oe});
         check("comp oe", {7'h0, &i}, {7'h0, drive[1].comp_oe});
         check("enabled toggles", (&i) ? 8'h8 : 8'h0, c);
      end
      cfg.output_enable_bits = 4'h0;
      tick(30);
      cfg.output_enable_bits = 4'hf;
      tick(1);
      c = {6'h0, drive[0].true_oe, drive[0].true_out};
      check("enable drives high", 8'h3, c);
      tick(24);
      toggles(0, 8, c);
      check("resumed toggles", 8'h8, c);
      c = {7'h0, drive[0].true_out ^ drive[0].comp_out};
      check("comp opposite", 8'h1, c);
   endtask : test_enable

   task automatic test_stop_driven();
      cfg.stop_allow_bits = 4'h5;
      cfg.stop_tristate_bit = 1'b0;
      stop_n = 1'b0;
      wait_stop(1'b1);
      tick(6);
      c = {4'h0, drive[0].true_out, drive[0].true_strong,
         drive[0].comp_oe, drive[0].comp_out};
      check("parked drive", 8'hc, c);
      check("parked oe", 8'h1, {7'h0, drive[0].true_oe});
      toggles(0, 8, c);
      check("parked toggles", 8'h0, c);
      toggles(1, 8, c);
      check("free pair toggles", 8'h8, c);
      cfg.output_enable_bits[2] = 1'b0;
      tick(30);
      check("parked off", 8'h1, {7'h0, drive[2] === DRIVE_OFF});
      cfg.output_enable_bits[2] = 1'b1;
      tick(6);
      stop_n = 1'b1;
      wait_stop(1'b0);
      tick(24);
      c = {7'h0, drive[2].true_out};
      check("pairs in step", {7'h0, drive[0].true_out}, c);
      toggles(2, 8, c);
      check("resumed pair", 8'h8, c);
   endtask : test_stop_driven

   task automatic test_stop_tristate();
      cfg.stop_tristate_bit = 1'b1;
      stop_n = 1'b0;
      wait_stop(1'b1);
      tick(6);
      c = {4'h0, drive[0].true_out, drive[0].true_oe,
         drive[0].comp_oe, drive[0].comp_out};
      check("floated stop", 8'h0, c);
      stop_n = 1'b1;
      wait_stop(1'b0);
      tick(1);
      check("release drives true", 8'h1, {7'h0, drive[0].true_oe});
      tick(24);
   endtask : test_stop_tristate

   task automatic test_short_pulse();
      logic seen;
      seen = 1'b0;
      stop_n = 1'b0;
      tick(1);
      stop_n = 1'b1;
      repeat (12) begin
         tick(1);
         if (stop_active !== 1'b0) seen = 1'b1;
      end
      check("short pulse ignored", 8'h0, {7'h0, seen});
   endtask : test_short_pulse

   task automatic test_half_rate();
      cfg.half_rate_bit = 1'b0;
      tick(24);
      check("half rate on", 8'h1, {7'h0, half_rate_active});
      toggles(3, 16, c);
      check("half rate toggles", 8'h8, c);
      cfg.half_rate_bit = 1'b1;
      tick(24);
      toggles(3, 16, c);
      check("full rate toggles", 8'h10, c);
   endtask : test_half_rate

   task automatic test_bypass();
      pll_pin = 1'b0;
      tick(10);
      toggles(0, 96, c);
      comparisons++;
      if (c < 8'h1c || c > 8'h21) begin
         failures++;
         $display("unexpected bypass toggles: expected 1c to 21, seen %0h",
            c);
      end
      // Bypass at half rate toggles once per input rising edge
      cfg.half_rate_bit = 1'b0;
      tick(16);
      toggles(0, 96, c);
      comparisons++;
      if (c < 8'he || c > 8'h11) begin
         failures++;
         $display("unexpected bypass half toggles: expected e to 11, seen %0h",
            c);
      end
      cfg.half_rate_bit = 1'b1;
      tick(16);
      pll_pin = 1'b1;
      tick(16);
   endtask : test_bypass

   initial begin
      failures = 0;
      comparisons = 0;
      rst_n = 1'b0;
      stop_n = 1'b1;
      pll_pin = 1'b1;
      bw_pin_n = 1'b1;
      en_pin = 4'h0;
      ref_run = 1'b1;
      cfg = '{half_rate_bit: 1'b1, stop_tristate_bit: 1'b0,
         pll_mode_bit: 1'b1, bandwidth_bit: 1'b1,
         output_enable_bits: 4'h0, stop_allow_bits: 4'h0};
      tick(8);
      rst_n = 1'b1;
      tick(1);
      test_reset();
      test_modes();
      test_enable();
      test_short_pulse();
      test_stop_driven();
      test_stop_tristate();
      test_half_rate();
      test_bypass();
      finish_test();
   end
endmodule : tb_top
